// file: rtl/shadow_pkg.sv
package shadow_pkg;
   localparam int WORDS = 16;
   localparam int WIDTH = 16;
   localparam int CLK_HZ = 40000000;
   localparam int STORE_TIME_US = 5000;
   localparam int RECALL_TIME_NS = 2000;
   localparam int STORE_CYCLES = STORE_TIME_US * (CLK_HZ / 1000000);
   localparam int RECALL_CYCLES_RAW = (RECALL_TIME_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int RECALL_CYCLES = (RECALL_CYCLES_RAW < 1) ? 1 : RECALL_CYCLES_RAW;
   localparam logic [2:0] OP_WRDIS = 3'h0;
   localparam logic [2:0] OP_SAVE = 3'h1;
   localparam logic [2:0] OP_ASEN = 3'h2;
   localparam logic [2:0] OP_WRITE = 3'h3;
   localparam logic [2:0] OP_WRITE_ENABLE_CMD = 3'h4;
   localparam logic [2:0] OP_RESTORE = 3'h5;
   localparam logic [7:0] IR_RESET = 8'h00;
   localparam logic [4:0] CNT_RESET = 5'h00;
   localparam logic [4:0] CNT_INSTR = 5'h08;
   localparam logic [4:0] CNT_DATA_LAST = 5'h17;
   localparam logic [3:0] BIT_MSB = 4'hF;
   typedef enum logic [1:0] {ST_BOOT = 2'b00, ST_IDLE = 2'b01, ST_STORE = 2'b11, ST_RECALL = 2'b10} nv_state_t;
endpackage

// file: rtl/shadow_if.sv
`timescale 1ns/1ps
interface shadow_if;
   logic start;
   logic busy;
   logic [22:0] count;
   modport ctrl (output start, input busy, input count);
   modport timer (input start, output busy, output count);
endinterface

// file: rtl/nv_timer.sv
`timescale 1ns/1ps
module nv_timer #(
   parameter int LEN = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   shadow_if.timer tif
);
   logic [22:0] cnt_q, cnt_d;
   logic busy_q, busy_d;

   // Busy held until the counter expires
   always_comb begin
      cnt_d = cnt_q;
      busy_d = busy_q;
      if (tif.start) begin
         cnt_d = 23'(LEN - 1);
         busy_d = 1'b1;
      end else if (busy_q) begin
         if (cnt_q == 23'h000000) begin
            busy_d = 1'b0;
         end else begin
            cnt_d = cnt_q - 23'h000001;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 23'h000000;
         busy_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         busy_q <= busy_d;
      end
   end

   assign tif.busy = busy_q;
   assign tif.count = cnt_q;
endmodule

// file: rtl/serial_shadow_ram_controller.sv
`timescale 1ns/1ps
module serial_shadow_ram_controller #(
   parameter int STORE_LEN = shadow_pkg::STORE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   output logic so_o,
   output logic so_oe,
   input wire logic recall_n,
   input wire logic supply_low,
   output logic low_supply_out_n_o,
   output logic low_supply_out_n_oe,
   output logic busy,
   output logic wr_en_latch,
   output logic prev_recall_latch,
   output logic auto_save_latch
);
   // ---------------------------------------------
   // Input synchronisers
   // ---------------------------------------------
   logic [4:0] sync1_q, sync2_q;
   logic sck_old_q;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // Idle pin levels, so no false edge follows reset
         sync1_q <= 5'h14;
         sync2_q <= 5'h14;
         sck_old_q <= 1'b0;
      end else begin
         sync1_q <= {recall_n, supply_low, cs_n, sck, si};
         sync2_q <= sync1_q;
         sck_old_q <= sync2_q[1];
      end
   end
   logic si_s, sck_s, cs_s, low_s, rcl_s;
   assign si_s = sync2_q[0];
   assign sck_s = sync2_q[1];
   assign cs_s = sync2_q[2];
   assign low_s = sync2_q[3];
   assign rcl_s = sync2_q[4];
   logic rise, fall;
   // Edges seen only on clock motion, so a stopped clock just holds state
   assign rise = sck_s & ~sck_old_q;
   assign fall = ~sck_s & sck_old_q;

   // ---------------------------------------------
   // Timers
   // ---------------------------------------------
   shadow_if st_if();
   shadow_if rc_if();
   nv_timer #(.LEN(STORE_LEN)) u_store (.clk_sys(clk_sys), .rst_n(rst_n), .tif(st_if.timer));
   nv_timer #(.LEN(shadow_pkg::RECALL_CYCLES)) u_recall (.clk_sys(clk_sys), .rst_n(rst_n), .tif(rc_if.timer));

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   logic [15:0] ram_q [shadow_pkg::WORDS];
   logic [15:0] nv_q [shadow_pkg::WORDS];
   logic [7:0] ir_q, ir_d;
   logic [4:0] cnt_q, cnt_d;
   logic [15:0] sh_q, sh_d;
   logic wpend_q, wpend_d;
   logic [3:0] obit_q, obit_d;
   logic so_q, so_d, oe_q, oe_d;
   logic wel_q, wel_d, prl_q, prl_d, ase_q, ase_d, as_q, as_d;
   logic rcl_old_q, rcl_old_d;
   logic armed_q, armed_d;
   logic busy_q, busy_d;
   shadow_pkg::nv_state_t st_q, st_d;
   logic commit, do_store, do_recall, set_prl;
   logic [7:0] ir_next;
   logic [3:0] waddr;

   always_comb begin
      ir_d = ir_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      wpend_d = wpend_q;
      obit_d = obit_q;
      so_d = so_q;
      oe_d = oe_q;
      wel_d = wel_q;
      prl_d = prl_q;
      ase_d = ase_q;
      as_d = as_q;
      st_d = st_q;
      rcl_old_d = rcl_s;
      armed_d = armed_q;
      commit = 1'b0;
      do_store = 1'b0;
      do_recall = 1'b0;
      set_prl = 1'b0;
      waddr = ir_q[6:3];
      ir_next = {ir_q[6:0], si_s};
      st_if.start = 1'b0;
      rc_if.start = 1'b0;
      unique case (st_q)
         shadow_pkg::ST_BOOT: begin
            // Power-up recall, latch stays clear, commands ignored
            if (!armed_q) begin
               rc_if.start = 1'b1;
               armed_d = 1'b1;
            end else if (!rc_if.busy) begin
               do_recall = 1'b1;
               st_d = shadow_pkg::ST_IDLE;
            end
         end
         shadow_pkg::ST_STORE: begin
            // Commands and the restore pin inhibited while saving
            if (!st_if.busy) begin
               wel_d = 1'b0;
               st_d = shadow_pkg::ST_IDLE;
            end
         end
         shadow_pkg::ST_RECALL: begin
            if (!rc_if.busy) begin
               do_recall = 1'b1;
               set_prl = 1'b1;
               st_d = shadow_pkg::ST_IDLE;
            end
         end
         shadow_pkg::ST_IDLE: begin
            if (cs_s) begin
               // Deselect: partial write still committed
               if (wpend_q && cnt_q > shadow_pkg::CNT_INSTR) begin
                  commit = 1'b1;
               end
               ir_d = shadow_pkg::IR_RESET;
               cnt_d = shadow_pkg::CNT_RESET;
               wpend_d = 1'b0;
               oe_d = 1'b0;
            end else if (rise) begin
               if (cnt_q < shadow_pkg::CNT_INSTR) begin
                  // Wait for start bit, then shift MSB first
                  if (cnt_q != shadow_pkg::CNT_RESET || si_s) begin
                     ir_d = ir_next;
                     cnt_d = cnt_q + 5'h01;
                  end
                  if (cnt_q == shadow_pkg::CNT_INSTR - 5'h01) begin
                     // Opcode decode on bits 2..0
                     unique case (ir_next[2:0])
                        shadow_pkg::OP_WRDIS: wel_d = 1'b0;
                        shadow_pkg::OP_WRITE_ENABLE_CMD: wel_d = 1'b1;
                        shadow_pkg::OP_ASEN: ase_d = 1'b1;
                        shadow_pkg::OP_RESTORE: begin
                           rc_if.start = 1'b1;
                           st_d = shadow_pkg::ST_RECALL;
                        end
                        shadow_pkg::OP_SAVE: begin
                           // Only with both latches set
                           if (wel_q && prl_q) begin
                              st_if.start = 1'b1;
                              st_d = shadow_pkg::ST_STORE;
                           end
                        end
                        shadow_pkg::OP_WRITE: begin
                           wpend_d = wel_q;
                           // Cleared so a short write carries no stale upper bits
                           sh_d = 16'h0000;
                        end
                        default: begin
                        end
                     endcase
                  end
                  // Read: bit0 ignored, first bit out on eighth fall
                  if (cnt_q == shadow_pkg::CNT_INSTR - 5'h01 && ir_next[2:1] == 2'b11) begin
                     sh_d = ram_q[ir_next[6:3]];
                     obit_d = shadow_pkg::BIT_MSB;
                     oe_d = 1'b1;
                  end
               end else if (wpend_q) begin
                  // Sixteen bits MSB first; beyond that, overwrite
                  sh_d = {sh_q[14:0], si_s};
                  if (cnt_q == shadow_pkg::CNT_DATA_LAST) begin
                     commit = 1'b1;
                     cnt_d = shadow_pkg::CNT_INSTR;
                  end else begin
                     cnt_d = cnt_q + 5'h01;
                  end
               end
            end else if (fall && oe_q) begin
               // Data changes on falling edge, MSB first
               so_d = sh_q[obit_q];
               if (obit_q == 4'h0) begin
                  obit_d = shadow_pkg::BIT_MSB;
               end else begin
                  obit_d = obit_q - 4'h1;
               end
            end
            if (!rcl_s && rcl_old_q && st_d == shadow_pkg::ST_IDLE) begin
               // Hardware restore pin
               rc_if.start = 1'b1;
               st_d = shadow_pkg::ST_RECALL;
            end
            if (low_s && ase_q && wel_q && st_d == shadow_pkg::ST_IDLE) begin
               // Low supply with auto-save enabled
               as_d = 1'b1;
               st_if.start = 1'b1;
               st_d = shadow_pkg::ST_STORE;
            end
         end
      endcase
      if (st_d != shadow_pkg::ST_IDLE) begin
         oe_d = 1'b0;
         wpend_d = 1'b0;
      end
      if (!low_s) begin
         as_d = 1'b0;
      end else if (ase_q) begin
         as_d = 1'b1;
      end
      if (set_prl) begin
         prl_d = 1'b1;
      end
      do_store = (st_q == shadow_pkg::ST_STORE) && !st_if.busy;
      busy_d = (st_d != shadow_pkg::ST_IDLE);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ir_q <= shadow_pkg::IR_RESET;
         cnt_q <= shadow_pkg::CNT_RESET;
         sh_q <= 16'h0000;
         wpend_q <= 1'b0;
         obit_q <= shadow_pkg::BIT_MSB;
         so_q <= 1'b0;
         oe_q <= 1'b0;
         wel_q <= 1'b0;
         prl_q <= 1'b0;
         ase_q <= 1'b0;
         as_q <= 1'b0;
         rcl_old_q <= 1'b1;
         st_q <= shadow_pkg::ST_BOOT;
         armed_q <= 1'b0;
         busy_q <= 1'b1;
      end else begin
         ir_q <= ir_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         wpend_q <= wpend_d;
         obit_q <= obit_d;
         so_q <= so_d;
         oe_q <= oe_d;
         wel_q <= wel_d;
         prl_q <= prl_d;
         ase_q <= ase_d;
         as_q <= as_d;
         rcl_old_q <= rcl_old_d;
         st_q <= st_d;
         armed_q <= armed_d;
         busy_q <= busy_d;
      end
   end

   // ---------------------------------------------
   // Arrays
   // ---------------------------------------------
   // No reset on arrays: contents model cells, not control state
   genvar gi;
   generate
      for (gi = 0; gi < shadow_pkg::WORDS; gi++) begin : g_word
         always_ff @(posedge clk_sys) begin
            if (do_recall) begin
               ram_q[gi] <= nv_q[gi];
            end else if (commit && waddr == 4'(gi)) begin
               // Next value, so the sixteenth bit lands too
               ram_q[gi] <= sh_d;
            end
            if (do_store) begin
               nv_q[gi] <= ram_q[gi];
            end
         end
      end
   endgenerate

   assign so_o = so_q;
   assign so_oe = oe_q;
   assign low_supply_out_n_o = 1'b0;
   assign low_supply_out_n_oe = as_q;
   assign busy = busy_q;
   assign wr_en_latch = wel_q;
   assign prev_recall_latch = prl_q;
   assign auto_save_latch = ase_q;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   chk_oe_deselect: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cs_s |=> !oe_q) else $error("output enabled while deselected");
   chk_save_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_if.start && !low_s |-> wel_q && prl_q) else $error("save started without latches");
   chk_save_clears_we: assert property (@(posedge clk_sys) disable iff (!rst_n)
      do_store |=> !wel_q) else $error("write enable kept after save");
   chk_boot_no_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_q == shadow_pkg::ST_BOOT |-> !prl_q) else $error("recall latch set at boot");
   chk_cs_clears_ir: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cs_s && st_q == shadow_pkg::ST_IDLE |=> ir_q == shadow_pkg::IR_RESET) else $error("ir kept");
   chk_recall_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
      set_prl |=> prl_q) else $error("recall latch not set");
   chk_start_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cnt_q == shadow_pkg::CNT_RESET && rise && !si_s && !cs_s |=> cnt_q == shadow_pkg::CNT_RESET)
      else $error("zero taken as start");
   chk_write_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(wpend_q) |-> $past(wel_q, 1)) else $error("write with latch clear");
endmodule

// file: sim/spi_host_model.sv
`timescale 1ns/1ps
// ----------------------------
// Host serial master, mode 0
// ----------------------------
module spi_host_model (
   input wire logic clk_sys,
   input wire logic so_o,
   input wire logic so_oe,
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic [39:0] rx,
   output logic oe_seen
);
   logic so_last;
   logic so_w;
   // Released line toggles so a stale bit never passes for data
   assign so_w = (so_oe === 1'b1) ? so_o : ~so_last;
   always @(posedge clk_sys) begin
      so_last <= so_w;
   end
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      so_last = 1'b0;
      rx = '0;
      oe_seen = 1'b0;
   end
   // Bits MSB first, sck idles low outside frames
   task automatic xfer(input int n, input logic [39:0] d, input int gap);
      int i;
      rx = '0;
      oe_seen = 1'b0;
      @(negedge clk_sys);
      cs_n = 1'b0;
      for (i = n - 1; i >= 0; i--) begin
         si = d[i];
         repeat (4) @(negedge clk_sys);
         sck = 1'b1;
         rx = {rx[38:0], so_w};
         oe_seen = oe_seen | so_oe;
         repeat (4) @(negedge clk_sys);
         sck = 1'b0;
         if (i == n - 5) begin
            repeat (gap) @(negedge clk_sys);
         end
      end
      repeat (4) @(negedge clk_sys);
      cs_n = 1'b1;
      si = 1'b0;
      repeat (12) @(negedge clk_sys);
   endtask
endmodule

// file: sim/serial_shadow_ram_controller_tb_top.sv
`timescale 1ns/1ps
// ----------
// Bench top
// ----------
module serial_shadow_ram_controller_tb_top;
   localparam int STORE_LEN = 400;
   logic clk_sys, rst_n, cs_n, sck, si, so_o, so_oe, recall_n, supply_low;
   logic low_supply_out_n_o, low_supply_out_n_oe, busy;
   logic wr_en_latch, prev_recall_latch, auto_save_latch, oe_seen;
   logic [39:0] rx;
   logic [15:0] v;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   serial_shadow_ram_controller #(.STORE_LEN(STORE_LEN)) u_dut (.clk_sys, .rst_n, .cs_n, .sck, .si, .so_o,
      .so_oe, .recall_n, .supply_low, .low_supply_out_n_o, .low_supply_out_n_oe, .busy, .wr_en_latch,
      .prev_recall_latch, .auto_save_latch);
   spi_host_model u_host (.clk_sys, .so_o, .so_oe, .cs_n, .sck, .si, .rx, .oe_seen);
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Sized well above the longest run so only a hang trips it
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         final_report;
      end
   end
   task automatic final_report;
      if (num_errors == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [7:0] ins(input logic [3:0] a, input logic [2:0] op);
      return {1'b1, a, op};
   endfunction
   task automatic cmd(input logic [2:0] op);
      u_host.xfer(8, {32'h0, ins(4'h0, op)}, 0);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      u_host.xfer(24, {16'h0, ins(a, shadow_pkg::OP_WRITE), d}, 0);
   endtask
   task automatic rd(input logic [3:0] a, input logic b0, input int gap);
      u_host.xfer(24, {16'h0, 1'b1, a, 2'b11, b0, 16'h0}, gap);
      v = rx[15:0];
   endtask
   task automatic wait_idle(input int lim);
      int k;
      for (k = 0; k < lim && busy !== 1'b0; k++) begin
         @(negedge clk_sys);
      end
      chk("busy_end", 16'h0, busy);
   endtask
   task automatic t_boot;
      repeat (4) @(negedge clk_sys);
      chk("boot_busy", 16'h1, busy);
      cmd(shadow_pkg::OP_WRITE_ENABLE_CMD);
      wait_idle(200);
      chk("boot_we", 16'h0, wr_en_latch);
      chk("boot_recall", 16'h0, prev_recall_latch);
      chk("boot_auto", 16'h0, auto_save_latch);
   endtask
   task automatic t_we;
      cmd(shadow_pkg::OP_WRITE_ENABLE_CMD);
      chk("we_set", 16'h1, wr_en_latch);
      wr(4'h5, 16'h1234);
      u_host.xfer(8, {32'h0, 8'hF8}, 0);
      chk("we_clr", 16'h0, wr_en_latch);
      wr(4'h5, 16'hFFFF);
      rd(4'h5, 1'b0, 0);
      chk("refused_wr", 16'h1234, v);
   endtask
   task automatic t_rw;
      cmd(shadow_pkg::OP_WRITE_ENABLE_CMD);
      u_host.xfer(27, {13'h0, ins(4'hF, shadow_pkg::OP_WRITE), 16'h8001}, 0); // leading zeros
      chk("oe_write", 16'h0, oe_seen);
      wr(4'h0, 16'h7E5A);
      rd(4'hF, 1'b1, 0);
      chk("rd_f", 16'h8001, v);
      chk("oe_after", 16'h0, so_oe);
      rd(4'h0, 1'b0, 60);
      chk("rd_stall", 16'h7E5A, v);
   endtask
   task automatic t_abort;
      u_host.xfer(16, {24'h0, ins(4'h2, shadow_pkg::OP_WRITE), 8'h5A}, 0);
      rd(4'h2, 1'b0, 0);
      chk("partial", 16'h005A, v);
      u_host.xfer(40, {ins(4'h7, shadow_pkg::OP_WRITE), 16'h1111, 16'hBEEF}, 0);
      rd(4'h7, 1'b0, 0);
      chk("overrun", 16'hBEEF, v);
      cmd(shadow_pkg::OP_WRDIS);
      u_host.xfer(4, 40'h8, 0);
      cmd(shadow_pkg::OP_WRITE_ENABLE_CMD);
      chk("ir_clear", 16'h1, wr_en_latch);
   endtask
   task automatic t_nv;
      cmd(shadow_pkg::OP_SAVE);
      chk("save_norecall", 16'h0, busy);
      cmd(shadow_pkg::OP_RESTORE);
      wait_idle(200);
      chk("rcl_latch", 16'h1, prev_recall_latch);
      wr(4'h3, 16'hC0DE);
      cmd(shadow_pkg::OP_WRDIS);
      cmd(shadow_pkg::OP_SAVE);
      chk("save_nowe", 16'h0, busy);
      cmd(shadow_pkg::OP_WRITE_ENABLE_CMD);
      cmd(shadow_pkg::OP_SAVE);
      chk("save_busy", 16'h1, busy);
      cmd(shadow_pkg::OP_ASEN);
      chk("save_hold", 16'h1, busy);
      wait_idle(STORE_LEN + 100);
      chk("save_we", 16'h0, wr_en_latch);
      chk("inhibit", 16'h0, auto_save_latch);
      cmd(shadow_pkg::OP_WRITE_ENABLE_CMD);
      wr(4'h3, 16'h0BAD);
      cmd(shadow_pkg::OP_RESTORE);
      wait_idle(200);
      rd(4'h3, 1'b0, 0);
      chk("nv_back", 16'hC0DE, v);
   endtask
   task automatic t_pin;
      rst_n = 1'b0;
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (10) @(negedge clk_sys);
      wait_idle(200);
      chk("rst_recall", 16'h0, prev_recall_latch);
      recall_n = 1'b0;
      repeat (10) @(negedge clk_sys);
      recall_n = 1'b1;
      wait_idle(200);
      chk("pin_recall", 16'h1, prev_recall_latch);
   endtask
   task automatic t_auto;
      cmd(shadow_pkg::OP_ASEN);
      chk("auto_set", 16'h1, auto_save_latch);
      cmd(shadow_pkg::OP_WRITE_ENABLE_CMD);
      supply_low = 1'b1;
      repeat (10) @(negedge clk_sys);
      chk("auto_busy", 16'h1, busy);
      chk("low_oe", 16'h1, low_supply_out_n_oe);
      chk("low_lvl", 16'h0, low_supply_out_n_o);
      supply_low = 1'b0;
      wait_idle(STORE_LEN + 100);
   endtask
   initial begin
      rst_n = 1'b0;
      recall_n = 1'b1;
      supply_low = 1'b0;
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      t_boot;
      t_we;
      t_rw;
      t_abort;
      t_nv;
      t_pin;
      t_auto;
      final_report;
   end
endmodule
